// File: logic/onchip_memory_pkg.sv
// constants, register map and reset values for the on-chip memory port controller
package onchip_memory_pkg;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] INSTR_RANGE_OFS = 8'h00;
	localparam logic [7:0] INSTR_CTRL_OFS  = 8'h04;
	localparam logic [7:0] DATA_RANGE_OFS  = 8'h08;
	localparam logic [7:0] DATA_CTRL_OFS   = 8'h0C;
	localparam logic [7:0] STATUS_OFS      = 8'h10;

	// ****************************************
	// field positions
	// ****************************************
	localparam int INSTR_EN_BIT  = 0;
	localparam int TWO_CYCLE_BIT = 1;
	localparam int DATA_EN_BIT   = 0;
	localparam int OPTION_BIT    = 1;
	localparam int RANGE_LSB     = 16;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] RANGE_RESET = 32'h0000_0000;
	localparam logic        TWO_CYCLE_RESET = 1'b1;
	localparam logic        OPTION_RESET    = 1'b1;
	localparam logic        ENABLE_RESET    = 1'b0;

	// ****************************************
	// bus responses
	// ****************************************
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : onchip_memory_pkg

// File: logic/onchip_memory_array.sv
// flip-flop storage array with one write port and two read ports
`timescale 1ns/1ns
module onchip_memory_array import onchip_memory_pkg::*; #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	// clock
	input  wire logic          clk,
	// data-side write port
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [31:0]   wrData,
	input  wire logic [3:0]    wrStrb,
	// instruction-side read
	input  wire logic [AW-1:0] instrAddr,
	output logic      [31:0]   instrWord,
	// data-side read
	input  wire logic [AW-1:0] dataAddr,
	output logic      [31:0]   dataWord
);

	logic [31:0] memWord [DEPTH];

	// ****************************************
	// per-entry byte-lane write
	// ****************************************
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge clk) begin
			for (int b = 0; b < 4; b++) begin
				if (wrEn && wrAddr == AW'(i) && wrStrb[b]) begin
					memWord[i][8*b +: 8] <= wrData[8*b +: 8];
				end
			end
		end
	end

	// combinational reads, shared array
	assign instrWord = memWord[instrAddr];
	assign dataWord  = memWord[dataAddr];

endmodule : onchip_memory_array

// File: logic/onchip_memory_port_control.sv
// two-port on-chip memory controller with an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module onchip_memory_port_control import onchip_memory_pkg::*; #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// register bus write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// register bus write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// register bus write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic      [1:0]  s_axi_bresp,
	// register bus read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// register bus read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	// instruction fetch port
	input  wire logic        instrReq,
	input  wire logic [31:0] instrAddr,
	output logic             instrClaim,
	output logic             instrDone,
	output logic      [31:0] instrData,
	// data access port
	input  wire logic        dataReq,
	input  wire logic        dataWrite,
	input  wire logic [31:0] dataAddr,
	input  wire logic [31:0] dataWdata,
	input  wire logic [3:0]  dataStrb,
	output logic             dataClaim,
	output logic             dataDone,
	output logic      [31:0] dataRdata
);

	typedef enum logic [1:0] {FETCH_IDLE, FETCH_WAIT} fetch_e;

	// ****************************************
	// state
	// ****************************************
	logic [31:0] instrRange_reg, instrRange_next;
	logic [31:0] dataRange_reg,  dataRange_next;
	logic        instrEn_reg,    instrEn_next;
	logic        twoCycle_reg,   twoCycle_next;
	logic        dataEn_reg,     dataEn_next;
	logic        option_reg,     option_next;
	fetch_e      fetch_reg,      fetch_next;
	logic        awHeld_reg,     awHeld_next;
	logic [7:0]  awAddr_reg,     awAddr_next;
	logic        wHeld_reg,      wHeld_next;
	logic [31:0] wData_reg,      wData_next;
	logic [3:0]  wStrb_reg,      wStrb_next;
	logic        bValid_reg,     bValid_next;
	logic [1:0]  bResp_reg,      bResp_next;
	logic        rValid_reg,     rValid_next;
	logic [31:0] rData_reg,      rData_next;
	logic [1:0]  rResp_reg,      rResp_next;
	logic        arReady_reg,    arReady_next;
	logic        iClaim_reg,     iClaim_next;
	logic        iDone_reg,      iDone_next;
	logic [31:0] iData_reg,      iData_next;
	logic        dClaim_reg,     dClaim_next;
	logic        dDone_reg,      dDone_next;
	logic [31:0] dData_reg,      dData_next;
	logic [31:0] iFetchAddr_reg, iFetchAddr_next;

	logic        instrHit;
	logic        dataHit;
	logic        memWrEn;
	logic [31:0] arrInstr;
	logic [31:0] arrData;
	logic [AW-1:0] iIndex;

	// ****************************************
	// address range decode
	// ****************************************
	// upper bits of each range register select a block of the address map
	// a held request is not taken again at the edge that shows its done
	assign instrHit = instrReq && instrEn_reg && !iDone_reg
		&& instrAddr[31:RANGE_LSB] == instrRange_reg[31:RANGE_LSB];
	assign dataHit = dataReq && dataEn_reg && !dDone_reg
		&& dataAddr[31:RANGE_LSB] == dataRange_reg[31:RANGE_LSB];
	assign memWrEn = dataHit && dataWrite;
	// second cycle of a two-cycle fetch reads the latched address
	assign iIndex = (fetch_reg == FETCH_WAIT) ? iFetchAddr_reg[AW+1:2]
		: instrAddr[AW+1:2];

	// ****************************************
	// storage
	// ****************************************
	onchip_memory_array #(.DEPTH(DEPTH), .AW(AW)) u_array (
		.clk       (clk),
		.wrEn      (memWrEn),
		.wrAddr    (dataAddr[AW+1:2]),
		.wrData    (dataWdata),
		.wrStrb    (dataStrb),
		.instrAddr (iIndex),
		.instrWord (arrInstr),
		.dataAddr  (dataAddr[AW+1:2]),
		.dataWord  (arrData)
	);

	// ****************************************
	// instruction and data port next state
	// ****************************************
	always_comb begin
		fetch_next      = fetch_reg;
		iFetchAddr_next = iFetchAddr_reg;
		iClaim_next     = instrHit;
		iDone_next      = 1'b0;
		iData_next      = iData_reg;
		dClaim_next     = dataHit;
		dDone_next      = dataHit;
		dData_next      = dataHit && !dataWrite ? arrData : dData_reg;
		case (fetch_reg)
			FETCH_IDLE: begin
				if (instrHit && twoCycle_reg) begin
					fetch_next      = FETCH_WAIT;
					iFetchAddr_next = instrAddr;
				end else if (instrHit) begin
					iDone_next = 1'b1;
					iData_next = arrInstr;
				end
			end
			FETCH_WAIT: begin
				fetch_next  = FETCH_IDLE;
				iClaim_next = 1'b1;
				iDone_next  = 1'b1;
				iData_next  = arrInstr;
			end
			default: fetch_next = FETCH_IDLE;
		endcase
	end

	// ****************************************
	// register bus next state
	// ****************************************
	always_comb begin
		logic [7:0] wa;
		logic       wok;
		wa = awAddr_reg;
		wok = 1'b1;
		instrRange_next = instrRange_reg;
		dataRange_next  = dataRange_reg;
		instrEn_next    = instrEn_reg;
		twoCycle_next   = twoCycle_reg;
		dataEn_next     = dataEn_reg;
		option_next     = option_reg;
		awHeld_next     = awHeld_reg;
		awAddr_next     = awAddr_reg;
		wHeld_next      = wHeld_reg;
		wData_next      = wData_reg;
		wStrb_next      = wStrb_reg;
		bValid_next     = bValid_reg && !s_axi_bready;
		bResp_next      = bResp_reg;
		rValid_next     = rValid_reg && !s_axi_rready;
		rData_next      = rData_reg;
		rResp_next      = rResp_reg;
		// capture address and data in either order
		if (s_axi_awvalid && !awHeld_reg && !bValid_reg) begin
			awHeld_next = 1'b1;
			awAddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_reg && !bValid_reg) begin
			wHeld_next = 1'b1;
			wData_next = s_axi_wdata;
			wStrb_next = s_axi_wstrb;
		end
		// commit a write once both halves are held
		if (awHeld_reg && wHeld_reg) begin
			awHeld_next = 1'b0;
			wHeld_next  = 1'b0;
			bValid_next = 1'b1;
			if (wa == INSTR_RANGE_OFS) begin
				for (int b = 0; b < 4; b++) begin
					if (wStrb_reg[b]) begin
						instrRange_next[8*b +: 8] = wData_reg[8*b +: 8];
					end
				end
			end else if (wa == DATA_RANGE_OFS) begin
				for (int b = 0; b < 4; b++) begin
					if (wStrb_reg[b]) begin
						dataRange_next[8*b +: 8] = wData_reg[8*b +: 8];
					end
				end
			end else if (wa == INSTR_CTRL_OFS) begin
				if (wStrb_reg[0]) begin
					instrEn_next  = wData_reg[INSTR_EN_BIT];
					twoCycle_next = wData_reg[TWO_CYCLE_BIT];
				end
			end else if (wa == DATA_CTRL_OFS) begin
				if (wStrb_reg[0]) begin
					dataEn_next = wData_reg[DATA_EN_BIT];
					option_next = wData_reg[OPTION_BIT];
				end
			end else if (wa == STATUS_OFS) begin
				wok = 1'b1; // read-only, write ignored
			end else begin
				wok = 1'b0;
			end
			bResp_next = wok ? RESP_OKAY : RESP_SLVERR;
		end
		// arready one cycle after arvalid, data after the handshake
		arReady_next = s_axi_arvalid && !arReady_reg && !rValid_reg;
		if (s_axi_arvalid && arReady_reg) begin
			rValid_next = 1'b1;
			rResp_next  = RESP_OKAY;
			if (s_axi_araddr == INSTR_RANGE_OFS) begin
				rData_next = instrRange_reg;
			end else if (s_axi_araddr == DATA_RANGE_OFS) begin
				rData_next = dataRange_reg;
			end else if (s_axi_araddr == INSTR_CTRL_OFS) begin
				rData_next = {30'h0, twoCycle_reg, instrEn_reg};
			end else if (s_axi_araddr == DATA_CTRL_OFS) begin
				rData_next = {30'h0, option_reg, dataEn_reg};
			end else if (s_axi_araddr == STATUS_OFS) begin
				rData_next = {30'h0, fetch_reg == FETCH_WAIT, awHeld_reg};
			end else begin
				rData_next = 32'h0000_0000;
				rResp_next = RESP_SLVERR;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			instrRange_reg <= RANGE_RESET;
			dataRange_reg  <= RANGE_RESET;
			instrEn_reg    <= ENABLE_RESET;
			twoCycle_reg   <= TWO_CYCLE_RESET;
			dataEn_reg     <= ENABLE_RESET;
			option_reg     <= OPTION_RESET;
			fetch_reg      <= FETCH_IDLE;
			awHeld_reg     <= 1'b0;
			awAddr_reg     <= 8'h00;
			wHeld_reg      <= 1'b0;
			wData_reg      <= 32'h0000_0000;
			wStrb_reg      <= 4'h0;
			bValid_reg     <= 1'b0;
			bResp_reg      <= RESP_OKAY;
			rValid_reg     <= 1'b0;
			rData_reg      <= 32'h0000_0000;
			rResp_reg      <= RESP_OKAY;
			arReady_reg    <= 1'b0;
			iClaim_reg     <= 1'b0;
			iDone_reg      <= 1'b0;
			iData_reg      <= 32'h0000_0000;
			dClaim_reg     <= 1'b0;
			dDone_reg      <= 1'b0;
			dData_reg      <= 32'h0000_0000;
			iFetchAddr_reg <= 32'h0000_0000;
		end else begin
			instrRange_reg <= instrRange_next;
			dataRange_reg  <= dataRange_next;
			instrEn_reg    <= instrEn_next;
			twoCycle_reg   <= twoCycle_next;
			dataEn_reg     <= dataEn_next;
			option_reg     <= option_next;
			fetch_reg      <= fetch_next;
			awHeld_reg     <= awHeld_next;
			awAddr_reg     <= awAddr_next;
			wHeld_reg      <= wHeld_next;
			wData_reg      <= wData_next;
			wStrb_reg      <= wStrb_next;
			bValid_reg     <= bValid_next;
			bResp_reg      <= bResp_next;
			rValid_reg     <= rValid_next;
			rData_reg      <= rData_next;
			rResp_reg      <= rResp_next;
			arReady_reg    <= arReady_next;
			iClaim_reg     <= iClaim_next;
			iDone_reg      <= iDone_next;
			iData_reg      <= iData_next;
			dClaim_reg     <= dClaim_next;
			dDone_reg      <= dDone_next;
			dData_reg      <= dData_next;
			iFetchAddr_reg <= iFetchAddr_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = awHeld_reg;
	assign s_axi_wready  = wHeld_reg;
	assign s_axi_bvalid  = bValid_reg;
	assign s_axi_bresp   = bResp_reg;
	assign s_axi_arready = arReady_reg;
	assign s_axi_rvalid  = rValid_reg;
	assign s_axi_rdata   = rData_reg;
	assign s_axi_rresp   = rResp_reg;
	assign instrClaim    = iClaim_reg;
	assign instrDone     = iDone_reg;
	assign instrData     = iData_reg;
	assign dataClaim     = dClaim_reg;
	assign dataDone      = dDone_reg;
	assign dataRdata     = dData_reg;

endmodule : onchip_memory_port_control

// File: test/memory_port_properties.sv
// assertions on the memory port controller pins
`timescale 1ns/1ns
module memory_port_checker import onchip_memory_pkg::*; (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// register bus
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	// memory ports
	input wire logic        instrReq,
	input wire logic        instrClaim,
	input wire logic        instrDone,
	input wire logic        dataReq,
	input wire logic        dataClaim,
	input wire logic        dataDone
);
	// single clock domain, reset masks all but the reset check
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped early");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data dropped early");
	property p_rnext;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rnext: assert property (p_rnext)
		else $error("read data late");
	property p_slverr;
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0;
	endproperty
	a_slverr: assert property (p_slverr)
		else $error("refused read returned data");
	property p_idone;
		instrDone |-> instrClaim && $past(instrReq);
	endproperty
	a_idone: assert property (p_idone)
		else $error("fetch done without a request");
	property p_iclaim;
		instrClaim |-> $past(instrReq);
	endproperty
	a_iclaim: assert property (p_iclaim)
		else $error("fetch claimed without a request");
	property p_dclaim;
		dataClaim |-> dataDone && $past(dataReq);
	endproperty
	a_dclaim: assert property (p_dclaim)
		else $error("data claim without request or done");
	property p_reset;
		disable iff (1'b0)
		!rst_n |=> !s_axi_bvalid && !s_axi_rvalid && !instrDone && !dataDone;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs active after reset");
endmodule // memory_port_checker

bind onchip_memory_port_control memory_port_checker memory_port_checker_inst (.*);

// File: test/core_access_model.sv
// behavioural fetch and data units of the processor core
`timescale 1ns/1ns
module core_access_model (
	// clock
	input wire logic        clk,
	// instruction side
	output logic            instrReq,
	output logic     [31:0] instrAddr,
	input wire logic        instrClaim,
	input wire logic        instrDone,
	input wire logic [31:0] instrData,
	// data side
	output logic            dataReq,
	output logic            dataWrite,
	output logic     [31:0] dataAddr,
	output logic     [31:0] dataWdata,
	input wire logic        dataClaim,
	input wire logic        dataDone,
	input wire logic [31:0] dataRdata
);
	// idle lines at time zero
	initial begin
		instrReq = 1'b0;
		dataReq = 1'b0;
		dataWrite = 1'b0;
		instrAddr = 32'h0000_0000;
		dataAddr = 32'h0000_0000;
		dataWdata = 32'h0000_0000;
	end

	// one access held until its done pulse or for at most 7 edges, then released
	task automatic access(input logic i, input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic c,
		output int lat);
		lat = 0;
		c = 1'b0;
		rd = 32'h0000_0000;
		@(posedge clk);
		instrReq <= i;
		dataReq <= !i;
		dataWrite <= w;
		instrAddr <= a;
		dataAddr <= a;
		dataWdata <= d;
		for (int n = 1; n < 8; n++) begin
			@(posedge clk);
			c |= i ? instrClaim : dataClaim;
			if (i ? instrDone : dataDone) begin
				rd = i ? instrData : dataRdata;
				lat = n - 1; // edges from the taking edge to done
				break;
			end
		end
		// released address and data lines show the inverse, requests drop, dataWrite keeps its value
		instrReq <= 1'b0;
		dataReq <= 1'b0;
		instrAddr <= ~a;
		dataAddr <= ~a;
		dataWdata <= ~d;
		repeat (3) @(posedge clk);
	endtask
endmodule // core_access_model

// File: test/onchip_memory_port_control_tb_top.sv
// self-checking bench for the on-chip memory port controller
`timescale 1ns/1ns
module onchip_memory_port_control_tb_top import onchip_memory_pkg::*;;
	// bench-driven inputs
	logic clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF, dataStrb = 4'hF;
	// design outputs and model lines
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, instrReq, instrClaim, instrDone, dataReq;
	logic dataWrite, dataClaim, dataDone;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, instrAddr, instrData;
	logic [31:0] dataAddr, dataWdata, dataRdata;
	// bench state
	int errTotal = 0, comparisons = 0, cycles = 0, lat, seed;
	logic [31:0] got, val [8];
	logic [5:0] idx [8];
	logic hit;
	localparam logic [31:0] BASE = 32'h5A3C_0000;
	localparam logic [31:0] MOVED = 32'h0C71_0000;
	localparam logic [31:0] NONE = 32'h0000_0000;

	onchip_memory_port_control onchip_memory_port_control_inst (.*);
	core_access_model core_access_model_inst (.*);

	// 20 MHz clock
	always #25 clk = ~clk;

	// hang guard far above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errTotal++;
			final_report();
		end
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errTotal++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// control word from enable and mode bits
	function automatic logic [31:0] ctrl(input logic en, input logic b1);
		return {30'h0000_0000, b1, en};
	endfunction

	// register write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				check(32'(s_axi_bresp), 32'(RESP_OKAY));
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask

	// register read with expected data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				check(s_axi_rdata, e);
				check(32'(s_axi_rresp), 32'(er));
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask

	// one core access through the model, claim compared
	task automatic acc(input logic i, input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic e);
		core_access_model_inst.access(i, w, a, d, got, hit, lat);
		check(32'(hit), 32'(e));
	endtask

	// main sequence
	initial begin
		seed = $urandom(97);
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(INSTR_RANGE_OFS, RANGE_RESET, RESP_OKAY);
		rd(DATA_RANGE_OFS, RANGE_RESET, RESP_OKAY);
		rd(INSTR_CTRL_OFS, ctrl(ENABLE_RESET, TWO_CYCLE_RESET), RESP_OKAY);
		rd(DATA_CTRL_OFS, ctrl(ENABLE_RESET, OPTION_RESET), RESP_OKAY);
		rd(8'h14, NONE, RESP_SLVERR);
		acc(1'b1, 1'b0, 32'h0000_0010, NONE, 1'b0);
		acc(1'b0, 1'b1, 32'h0000_0010, NONE, 1'b0);
		$display("test reset state ended");
		// disable, place, enable, in that order
		wr(DATA_CTRL_OFS, ctrl(1'b0, 1'b1));
		wr(DATA_RANGE_OFS, BASE);
		wr(DATA_CTRL_OFS, ctrl(1'b1, 1'b1));
		wr(INSTR_CTRL_OFS, ctrl(1'b0, 1'b1));
		wr(INSTR_RANGE_OFS, BASE);
		wr(INSTR_CTRL_OFS, ctrl(1'b1, 1'b1));
		// random words preloaded, last one at the top word
		for (int i = 0; i < 8; i++) begin
			idx[i] = (i == 7) ? 6'h3F : 6'(i * 8 + $urandom_range(7));
			val[i] = $urandom;
			acc(1'b0, 1'b1, BASE | {idx[i], 2'b00}, val[i], 1'b1);
		end
		$display("test preload ended");
		// both ports read back, two-cycle then single-cycle fetch
		for (int m = 0; m < 2; m++) begin
			if (m == 1) wr(INSTR_CTRL_OFS, ctrl(1'b1, 1'b0));
			for (int i = 0; i < 8; i++) begin
				acc(1'b0, 1'b0, BASE | {idx[i], 2'b00}, NONE, 1'b1);
				check(got, val[i]);
				acc(1'b1, 1'b0, BASE | {idx[i], 2'b00}, NONE, 1'b1);
				check(got, val[i]);
				check(32'(lat), 32'(2 - m));
			end
		end
		acc(1'b1, 1'b0, BASE ^ 32'h0001_0000, NONE, 1'b0);
		acc(1'b0, 1'b0, BASE ^ 32'h0001_0000, NONE, 1'b0);
		$display("test fetch modes ended");
		// move the instruction window away from the data window
		wr(INSTR_CTRL_OFS, ctrl(1'b0, 1'b0));
		wr(INSTR_RANGE_OFS, MOVED);
		wr(INSTR_CTRL_OFS, ctrl(1'b1, 1'b0));
		acc(1'b1, 1'b0, BASE, NONE, 1'b0);
		acc(1'b1, 1'b0, MOVED | {idx[0], 2'b00}, NONE, 1'b1);
		check(got, val[0]);
		rd(DATA_CTRL_OFS, ctrl(1'b1, 1'b1), RESP_OKAY);
		// ports switched off again
		wr(DATA_CTRL_OFS, ctrl(1'b0, 1'b1));
		acc(1'b0, 1'b0, BASE, NONE, 1'b0);
		wr(INSTR_CTRL_OFS, ctrl(1'b0, 1'b0));
		acc(1'b1, 1'b0, MOVED, NONE, 1'b0);
		// second reset brings two-cycle mode back
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(INSTR_CTRL_OFS, ctrl(ENABLE_RESET, TWO_CYCLE_RESET), RESP_OKAY);
		$display("test remap and second reset ended");
		final_report();
	end
endmodule // onchip_memory_port_control_tb_top
